// [core/fan_tachometer_counter.sv]
// Purpose: two fan tachometer channels behind an AHB-Lite slave
// Assumes: tach inputs are synchronous to clk; rst is the
//          standby power-on reset of the register file
// Notes:   a pulse runs from one tach rising edge to the next
`timescale 1ns/100ps
`include "ftc_defs.svh"

module fan_tachometer_counter #(
   parameter logic [`FTC_PER_W-1:0] BASE_PER0 = `FTC_BASE_PER0,
   parameter logic [`FTC_PER_W-1:0] BASE_PER1 = `FTC_BASE_PER1,
   parameter logic [`FTC_PER_W-1:0] BASE_PER2 = `FTC_BASE_PER2,
   parameter logic [`FTC_PER_W-1:0] BASE_PER3 = `FTC_BASE_PER3
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        fanOneTach,
   input  wire logic        fanTwoTach
);

   // ==========================================================
   // declarations
   localparam int NCH = 2;

   logic                    wrStrobe;
   ftc_pkg::ftc_reg_t       wrReg;
   logic [7:0]              wrData;
   logic                    rdStrobe;
   ftc_pkg::ftc_reg_t       rdReg;
   logic [7:0]              rdValue;

   logic [7:0]              ctrl_q;
   logic [7:0]              ctrl_d;
   logic [7:0]              preload_q;
   logic [7:0]              preload_d;
   logic [7:0]              clkSel_q;
   logic [7:0]              clkSel_d;
   logic                    preloadWrite;

   ftc_pkg::ftc_chan_cfg_t  cfg       [NCH];
   logic                    restart   [NCH];
   logic                    tick      [NCH];
   logic                    tachIn    [NCH];
   logic [7:0]              startVal  [NCH];

   ftc_pkg::ftc_chan_state_t state_q  [NCH];
   ftc_pkg::ftc_chan_state_t state_d  [NCH];
   logic                    tachPrev_q [NCH];
   logic                    tachPrev_d [NCH];
   logic [7:0]              count_q   [NCH];
   logic [7:0]              count_d   [NCH];
   logic [7:0]              result_q  [NCH];
   logic [7:0]              result_d  [NCH];

   // ==========================================================
   // bus front end
   ftc_ahb_port u_bus (
      .clk       (clk),
      .rst       (rst),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata),
      .wrStrobe  (wrStrobe),
      .wrReg     (wrReg),
      .wrData    (wrData),
      .rdStrobe  (rdStrobe),
      .rdReg     (rdReg),
      .rdValue   (rdValue)
   );

   // ==========================================================
   // software registers: next values
   always_comb begin
      ctrl_d = ctrl_q;
      preload_d = preload_q;
      clkSel_d = clkSel_q;
      preloadWrite = 1'b0;
      if (wrStrobe) begin
         unique case (wrReg)
            ftc_pkg::REG_CTRL: begin
               ctrl_d = wrData;
            end
            ftc_pkg::REG_PRELOAD1: begin
               preload_d = wrData;
               preloadWrite = 1'b1;
            end
            ftc_pkg::REG_CLKSEL: begin
               clkSel_d = wrData & `FTC_CLKSEL_MASK;
            end
            ftc_pkg::REG_COUNT1,
            ftc_pkg::REG_COUNT2,
            ftc_pkg::REG_NONE: begin
               ctrl_d = ctrl_q;          // read-only or unmapped
            end
         endcase
      end
   end

   // software registers: storage
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q <= `FTC_RST_CTRL;
         preload_q <= `FTC_RST_PRELOAD;
         clkSel_q <= `FTC_RST_CLKSEL;
      end else begin
         ctrl_q <= ctrl_d;
         preload_q <= preload_d;
         clkSel_q <= clkSel_d;
      end
   end

   // ==========================================================
   // per channel rate settings from the control and clock select registers
   always_comb begin
      cfg[0].clkSrc = ctrl_q[`FTC_CTRL_SRC1];
      cfg[0].clkSel = clkSel_q[`FTC_CLKSEL_FIRST_FAN_CHANNEL];
      cfg[0].mult   = ctrl_q[`FTC_CTRL_MULT1];
      cfg[0].div    = ctrl_q[`FTC_CTRL_DIV1];
      cfg[1].clkSrc = ctrl_q[`FTC_CTRL_SRC2];
      cfg[1].clkSel = clkSel_q[`FTC_CLKSEL_SECOND_FAN_CHANNEL];
      cfg[1].mult   = ctrl_q[`FTC_CTRL_MULT2];
      cfg[1].div    = ctrl_q[`FTC_CTRL_DIV2];
   end

   // channel inputs: tach pins, start values, restarts
   always_comb begin
      tachIn[0]   = fanOneTach;
      tachIn[1]   = fanTwoTach;
      startVal[0] = preload_d;
      startVal[1] = `FTC_SECOND_FAN_CHANNEL_PRELOAD;
      restart[0]  = preloadWrite;
      restart[1]  = 1'b0;
   end

   // ==========================================================
   // tick generators, one per channel
   for (genvar ch = 0; ch < NCH; ch++) begin : g_tick
      ftc_tick_gen #(
         .BASE_PER0 (BASE_PER0),
         .BASE_PER1 (BASE_PER1),
         .BASE_PER2 (BASE_PER2),
         .BASE_PER3 (BASE_PER3)
      ) u_tick (
         .clk     (clk),
         .rst     (rst),
         .restart (restart[ch]),
         .cfg     (cfg[ch]),
         .tick    (tick[ch])
      );
   end

   // ==========================================================
   // pulse measurement: next values
   always_comb begin
      for (int ch = 0; ch < NCH; ch++) begin
         state_d[ch] = state_q[ch];
         tachPrev_d[ch] = tachIn[ch];
         count_d[ch] = count_q[ch];
         result_d[ch] = result_q[ch];
         if (restart[ch]) begin
            // old result kept; software waits out two pulses
            state_d[ch] = ftc_pkg::CH_ARMED;
            count_d[ch] = startVal[ch];
         end else begin
            unique case (state_q[ch])
               ftc_pkg::CH_ARMED: begin
                  // partial pulse after restart is discarded
                  if (tachIn[ch] & ~tachPrev_q[ch]) begin
                     state_d[ch] = ftc_pkg::CH_COUNTING;
                     count_d[ch] = startVal[ch];
                  end
               end
               ftc_pkg::CH_COUNTING: begin
                  if (tachIn[ch] & ~tachPrev_q[ch]) begin
                     result_d[ch] = count_q[ch];
                     count_d[ch] = startVal[ch];
                  end else if (tick[ch] &&
                               count_q[ch] != `FTC_COUNT_MAX) begin
                     count_d[ch] = count_q[ch] + 8'h01;
                  end
               end
            endcase
         end
      end
   end

   // pulse measurement: storage
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int ch = 0; ch < NCH; ch++) begin
            state_q[ch] <= ftc_pkg::CH_ARMED;
            tachPrev_q[ch] <= 1'b0;
            count_q[ch] <= `FTC_RST_COUNT;
            result_q[ch] <= `FTC_RST_COUNT;
         end
      end else begin
         for (int ch = 0; ch < NCH; ch++) begin
            state_q[ch] <= state_d[ch];
            tachPrev_q[ch] <= tachPrev_d[ch];
            count_q[ch] <= count_d[ch];
            result_q[ch] <= result_d[ch];
         end
      end
   end

   // ==========================================================
   // read mux; written registers forward their next value
   always_comb begin
      rdValue = 8'h00;
      if (rdStrobe) begin
         unique case (rdReg)
            ftc_pkg::REG_CTRL:     rdValue = ctrl_d;
            ftc_pkg::REG_COUNT1:   rdValue = result_q[0];
            ftc_pkg::REG_COUNT2:   rdValue = result_q[1];
            ftc_pkg::REG_PRELOAD1: rdValue = preload_d;
            ftc_pkg::REG_CLKSEL:   rdValue = clkSel_d;
            ftc_pkg::REG_NONE:     rdValue = 8'h00;
         endcase
      end
   end

endmodule

// [core/ftc_defs.svh]
// Purpose: shared constants of the fan tachometer counter
// Assumes: included by the package and by every module except the fan model
// Notes:   offsets are byte addresses of aligned 32-bit words
`ifndef FTC_DEFS_SVH
`define FTC_DEFS_SVH

// ==========================================================
// register byte offsets
`define FTC_OFS_CTRL     8'h00
`define FTC_OFS_COUNT1   8'h04
`define FTC_OFS_COUNT2   8'h08
`define FTC_OFS_PRELOAD1 8'h0C
`define FTC_OFS_CLKSEL   8'h10

// ==========================================================
// field positions
`define FTC_CTRL_SRC1    0
`define FTC_CTRL_SRC2    1
`define FTC_CTRL_MULT1   2
`define FTC_CTRL_MULT2   3
`define FTC_CTRL_DIV1    5:4
`define FTC_CTRL_DIV2    7:6
`define FTC_CLKSEL_FIRST_FAN_CHANNEL  0
`define FTC_CLKSEL_SECOND_FAN_CHANNEL  1
`define FTC_CLKSEL_MASK  8'h03

// ==========================================================
// reset values and fixed values
`define FTC_RST_CTRL     8'h50
`define FTC_RST_PRELOAD  8'h00
`define FTC_RST_COUNT    8'h00
`define FTC_RST_CLKSEL   8'h00
`define FTC_SECOND_FAN_CHANNEL_PRELOAD 8'h00
`define FTC_COUNT_MAX    8'hFF
`define FTC_HSIZE_WORD   3'h2

// ==========================================================
// timing: base tick periods in clk cycles per clkSrc/clkSel
`define FTC_PER_W        20
`define FTC_BASE_PER0    20'h00100
`define FTC_BASE_PER1    20'h00200
`define FTC_BASE_PER2    20'h00400
`define FTC_BASE_PER3    20'h00800

`endif

// [core/ftc_pkg.sv]
// Purpose: types and shared functions of the fan tachometer counter
// Assumes: constants come from ftc_defs.svh
// Notes:   nothing here holds state
`include "ftc_defs.svh"

package ftc_pkg;

   // ==========================================================
   // register selector and bus phase carrier
   typedef enum logic [2:0] {
      REG_CTRL, REG_COUNT1, REG_COUNT2, REG_PRELOAD1, REG_CLKSEL, REG_NONE
   } ftc_reg_t;

   typedef struct packed {
      logic     valid;
      logic     write;
      ftc_reg_t sel;
   } ftc_bus_phase_t;

   // per channel rate settings
   typedef struct packed {
      logic       clkSrc;
      logic       clkSel;
      logic       mult;
      logic [1:0] div;
   } ftc_chan_cfg_t;

   // channel measuring state
   typedef enum logic {CH_ARMED, CH_COUNTING} ftc_chan_state_t;

   // ==========================================================
   // address decode, shared by read and write paths
   function automatic ftc_reg_t ftc_reg_decode(input logic [31:0] addr);
      ftc_reg_t r;
      r = REG_NONE;
      if (addr[31:8] == 24'h000000) begin
         case (addr[7:0])
            `FTC_OFS_CTRL:     r = REG_CTRL;
            `FTC_OFS_COUNT1:   r = REG_COUNT1;
            `FTC_OFS_COUNT2:   r = REG_COUNT2;
            `FTC_OFS_PRELOAD1: r = REG_PRELOAD1;
            `FTC_OFS_CLKSEL:   r = REG_CLKSEL;
            default:           r = REG_NONE;
         endcase
      end
      return r;
   endfunction

   // tick period: doubler halves it, divisor 1/2/4/8 stretches it
   function automatic logic [`FTC_PER_W-1:0] ftc_tick_period(
      input logic [`FTC_PER_W-1:0] base,
      input logic                  mult,
      input logic [1:0]            div);
      logic [`FTC_PER_W-1:0] p;
      p = mult ? (base >> 1) : base;
      p = p << div;
      if (p == '0) begin
         p = {{(`FTC_PER_W-1){1'b0}}, 1'b1};
      end
      return p;
   endfunction

endpackage

// [core/ftc_tick_gen.sv]
// Purpose: counting tick of one tachometer channel
// Assumes: base periods are at least two cycles
// Notes:   restart realigns the prescaler to the new count
`timescale 1ns/100ps
`include "ftc_defs.svh"

module ftc_tick_gen #(
   parameter logic [`FTC_PER_W-1:0] BASE_PER0 = `FTC_BASE_PER0,
   parameter logic [`FTC_PER_W-1:0] BASE_PER1 = `FTC_BASE_PER1,
   parameter logic [`FTC_PER_W-1:0] BASE_PER2 = `FTC_BASE_PER2,
   parameter logic [`FTC_PER_W-1:0] BASE_PER3 = `FTC_BASE_PER3
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   restart,
   input  wire ftc_pkg::ftc_chan_cfg_t cfg,
   output logic                        tick
);

   logic [`FTC_PER_W-1:0] prescale_q;
   logic [`FTC_PER_W-1:0] prescale_d;
   logic                  tick_q;
   logic                  tick_d;
   logic [`FTC_PER_W-1:0] base;
   logic [`FTC_PER_W-1:0] period;

   // ==========================================================
   // base speed from source and select, then scaled
   always_comb begin
      unique case ({cfg.clkSrc, cfg.clkSel})
         2'b00: base = BASE_PER0;
         2'b01: base = BASE_PER1;
         2'b10: base = BASE_PER2;
         2'b11: base = BASE_PER3;
      endcase
      period = ftc_pkg::ftc_tick_period(base, cfg.mult, cfg.div);
      prescale_d = prescale_q + {{(`FTC_PER_W-1){1'b0}}, 1'b1};
      tick_d = 1'b0;
      if (restart) begin
         prescale_d = '0;
      end else if (prescale_q >= period - {{(`FTC_PER_W-1){1'b0}}, 1'b1}) begin
         prescale_d = '0;
         tick_d = 1'b1;
      end
   end

   // prescaler registers
   always_ff @(posedge clk) begin
      if (rst) begin
         prescale_q <= '0;
         tick_q <= 1'b0;
      end else begin
         prescale_q <= prescale_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;

endmodule

// [core/ftc_ahb_port.sv]
// Purpose: AHB-Lite slave front end of the register file
// Assumes: one slave, zero wait states, response always OKAY
// Notes:   writes land in the data phase; reads sample in address phase
`timescale 1ns/100ps
`include "ftc_defs.svh"

module ftc_ahb_port (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   output logic                   wrStrobe,
   output ftc_pkg::ftc_reg_t      wrReg,
   output logic [7:0]             wrData,
   output logic                   rdStrobe,
   output ftc_pkg::ftc_reg_t      rdReg,
   input  wire logic [7:0]        rdValue
);

   ftc_pkg::ftc_bus_phase_t phase_q;
   ftc_pkg::ftc_bus_phase_t phase_d;
   logic [31:0]             hrdata_q;
   logic [31:0]             hrdata_d;
   logic                    accept;

   // ==========================================================
   // address phase capture and read sampling
   always_comb begin
      accept = hsel & hready & htrans[1];
      rdStrobe = accept & ~hwrite;
      rdReg = ftc_pkg::ftc_reg_decode(haddr);
      phase_d.valid = accept & (hsize == `FTC_HSIZE_WORD);
      phase_d.write = hwrite;
      phase_d.sel = rdReg;
      hrdata_d = rdStrobe ? {24'h000000, rdValue} : hrdata_q;
   end

   // bus registers
   always_ff @(posedge clk) begin
      if (rst) begin
         phase_q <= '{valid: 1'b0, write: 1'b0, sel: ftc_pkg::REG_NONE};
         hrdata_q <= 32'h00000000;
      end else begin
         phase_q <= phase_d;
         hrdata_q <= hrdata_d;
      end
   end

   // data phase write strobe and fixed answers
   assign wrStrobe = phase_q.valid & phase_q.write;
   assign wrReg = phase_q.sel;
   assign wrData = hwdata[7:0];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;

endmodule

// [verification/ftc_checker_sva.sv]
// Purpose: bus and count checks at the top ports
// Assumes: hready is tied to hreadyout
// Notes:   shadows follow control and preload writes
`timescale 1ns/100ps
`include "ftc_defs.svh"

// ==========================================================
// checker
module ftc_checker (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        fanOneTach,
   input wire logic        fanTwoTach
);
   logic        rdTake, wrTake, rdCnt;
   logic [7:0]  ctrlNow, preNow, ctrl_q, ctrl_d, pre_q, pre_d;
   logic [7:0]  last_q, last_d;
   logic        wrC_q, wrC_d, wrP_q, wrP_d, rdDly_q, rdDly_d;
   logic        seen_q, seen_d, tach_q, tach_d;
   logic [15:0] quiet_q, quiet_d, since_q, since_d;

   // decode and shadow next values
   always_comb begin
      rdTake  = hsel && hready && htrans[1] && !hwrite;
      wrTake  = hsel && hready && htrans[1] && hwrite &&
                hsize == `FTC_HSIZE_WORD;
      rdCnt   = rdTake && haddr == {24'h000000, `FTC_OFS_COUNT1};
      ctrlNow = wrC_q ? hwdata[7:0] : ctrl_q;
      preNow  = wrP_q ? hwdata[7:0] : pre_q;
      wrC_d   = wrTake && haddr == {24'h000000, `FTC_OFS_CTRL};
      wrP_d   = wrTake && haddr == {24'h000000, `FTC_OFS_PRELOAD1};
      ctrl_d  = ctrlNow;
      pre_d   = preNow;
      rdDly_d = rdCnt;
      last_d  = rdDly_q ? hrdata[7:0] : last_q;
      seen_d  = seen_q || rdDly_q;
      tach_d  = fanOneTach;
      quiet_d = quiet_q + {15'h0000, quiet_q != 16'hFFFF};
      if (fanOneTach && !tach_q) begin
         quiet_d = 16'h0000;
      end
      since_d = rdCnt ? 16'h0000 : since_q + {15'h0000, since_q != 16'hFFFF};
   end

   // shadow registers
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q  <= `FTC_RST_CTRL;
         pre_q   <= `FTC_RST_PRELOAD;
         wrC_q   <= 1'b0;
         wrP_q   <= 1'b0;
         rdDly_q <= 1'b0;
         seen_q  <= 1'b0;
         quiet_q <= 16'h0000;
         since_q <= 16'h0000;
      end else begin
         ctrl_q  <= ctrl_d;
         pre_q   <= pre_d;
         wrC_q   <= wrC_d;
         wrP_q   <= wrP_d;
         rdDly_q <= rdDly_d;
         seen_q  <= seen_d;
         quiet_q <= quiet_d;
         since_q <= since_d;
      end
      last_q <= last_d;
      tach_q <= tach_d;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_READY_ALWAYS: assert property (hreadyout == 1'b1)
      else $error("hreadyout low");
   AST_RESP_OKAY: assert property (hresp == 1'b0)
      else $error("hresp not okay");
   AST_RDATA_BYTE: assert property (rdTake |=> hrdata[31:8] == 24'h000000)
      else $error("read data upper bits set");
   AST_RDATA_HOLD: assert property (!rdTake |=> $stable(hrdata))
      else $error("read data changed without read");
   AST_UNMAPPED_ZERO: assert property (
      rdTake && haddr == 32'h00000014 |=> hrdata == 32'h00000000)
      else $error("unmapped read not zero");
   AST_CTRL_READBACK: assert property (
      rdTake && haddr == {24'h000000, `FTC_OFS_CTRL}
      |=> hrdata == {24'h000000, $past(ctrlNow)})
      else $error("control readback wrong");
   AST_PRELOAD_READBACK: assert property (
      rdTake && haddr == {24'h000000, `FTC_OFS_PRELOAD1}
      |=> hrdata == {24'h000000, $past(preNow)})
      else $error("preload readback wrong");
   AST_COUNT1_HOLD: assert property (
      rdCnt && seen_q && quiet_q > since_q + 16'h0003
      |=> hrdata[7:0] == last_q)
      else $error("count changed without pulse end");
endmodule

bind fan_tachometer_counter ftc_checker ftc_checker_inst (
   .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .fanOneTach(fanOneTach), .fanTwoTach(fanTwoTach));

// [verification/ftc_fan_model.sv]
// Purpose: fan tachometer output with a fixed pulse period
// Assumes: halfCyc is at least one cycle
// Notes:   a stopped fan holds its output low
`timescale 1ns/100ps

// ==========================================================
// fan model
module ftc_fan_model (
   input  wire logic       clk,
   input  wire logic       run,
   input  wire logic [7:0] halfCyc,
   output logic            tach
);
   logic [8:0] ph_q, ph_d;

   // phase within one pulse, high half first
   always_comb begin
      ph_d = 9'h000;
      if (run && ph_q != {halfCyc, 1'b0} - 9'h001) begin
         ph_d = ph_q + 9'h001;
      end
      tach = run && ph_q < {1'b0, halfCyc};
   end

   // phase register
   always_ff @(posedge clk) begin
      ph_q <= ph_d;
   end
endmodule

// [verification/tb_top.sv]
// Purpose: self-checking bench of the fan tachometer counter
// Assumes: short base periods 2, 4, 6 and 8 cycles
// Notes:   fan one pulse 96 cycles, fan two 48 cycles; 64 and 32 in the restart test
`timescale 1ns/100ps
`include "ftc_defs.svh"

// ==========================================================
// bench top
module tb_top;
   localparam logic [31:0] A_CTRL = {24'h000000, `FTC_OFS_CTRL};
   localparam logic [31:0] A_CNT1 = {24'h000000, `FTC_OFS_COUNT1};
   localparam logic [31:0] A_CNT2 = {24'h000000, `FTC_OFS_COUNT2};
   localparam logic [31:0] A_PRE  = {24'h000000, `FTC_OFS_PRELOAD1};
   localparam logic [31:0] A_SEL  = {24'h000000, `FTC_OFS_CLKSEL};
   localparam int          BASES [4] = '{2, 4, 6, 8};
   logic        clk, rst, hsel, hwrite, hreadyout, hresp, fanRun;
   logic        fanOneTach, fanTwoTach;
   logic [31:0] haddr, hwdata, hrdata, rdVal;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  halfOne, halfTwo;
   int          n_mismatch, n_checks;

   fan_tachometer_counter #(.BASE_PER0(20'h00002), .BASE_PER1(20'h00004),
      .BASE_PER2(20'h00006), .BASE_PER3(20'h00008))
   fan_tachometer_counter_inst (.clk(clk), .rst(rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .fanOneTach(fanOneTach),
      .fanTwoTach(fanTwoTach));
   ftc_fan_model fanOneModel (.clk(clk), .run(fanRun), .halfCyc(halfOne),
      .tach(fanOneTach));
   ftc_fan_model fanTwoModel (.clk(clk), .run(fanRun), .halfCyc(halfTwo),
      .tach(fanTwoTach));

   // clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // comparisons
   task automatic checkEq(input string what, input logic [31:0] exp,
                          input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic checkRange(input string what, input logic [7:0] lo,
                             input logic [7:0] hi, input logic [7:0] got);
      n_checks++;
      if ($isunknown(got) || got < lo || got > hi) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h..%h seen %h", what, lo, hi,
                  got);
      end
   endtask

   // one single AHB transfer, address phase then data phase
   task automatic busXfer(input logic wr, input logic [31:0] addr,
                          input logic [31:0] wdata,
                          output logic [31:0] rdata);
      hsel <= 1'b1;
      haddr <= addr;
      hwrite <= wr;
      htrans <= 2'h2;
      do begin
         @(posedge clk);
      end while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wdata;
      do begin
         @(posedge clk);
      end while (hreadyout !== 1'b1);
      rdata = hrdata;
   endtask
   task automatic writeReg(input logic [31:0] addr, input logic [31:0] d);
      busXfer(1'b1, addr, d, rdVal);
   endtask
   task automatic readCheck(input logic [31:0] addr,
                            input logic [31:0] exp, input string what);
      busXfer(1'b0, addr, 32'h00000000, rdVal);
      checkEq(what, exp, rdVal);
   endtask
   task automatic readRange(input logic [31:0] addr, input int lo,
                            input int hi, input string what);
      busXfer(1'b0, addr, 32'h00000000, rdVal);
      checkRange(what, 8'(lo), 8'(hi), rdVal[7:0]);
   endtask

   // tick period in cycles from source, doubler and divisor
   function automatic int tickPer(input logic [1:0] idx, input logic m,
                                  input logic [1:0] d);
      int p;
      p = m ? BASES[idx] / 2 : BASES[idx];
      p = p << d;
      return (p == 0) ? 1 : p;
   endfunction

   // reset values, read-only and unmapped places
   task automatic testResetValues();
      readCheck(A_CTRL, 32'h00000050, "ctrl");
      readCheck(A_CNT1, 32'h00000000, "count1");
      readCheck(A_CNT2, 32'h00000000, "count2");
      readCheck(A_PRE, 32'h00000000, "preload");
      readCheck(A_SEL, 32'h00000000, "clksel");
      readCheck(32'h00000014, 32'h00000000, "unmapped");
      writeReg(A_CNT1, 32'h000000AA);
      readCheck(A_CNT1, 32'h00000000, "count1 ro");
   endtask

   // every doubler and divisor code, then source 1 with both clock selects
   task automatic testRates();
      logic [7:0] ctrl;
      logic [1:0] sel, d;
      logic       m;
      int         n1, n2;
      for (int i = 0; i < 10; i++) begin
         m = (i < 8) ? i[0] : 1'b0;
         d = (i < 8) ? i[2:1] : 2'h0;
         sel = (i == 9) ? 2'h3 : 2'h0;
         ctrl = (i < 8) ? {d, d, m, m, 2'h0} : 8'h03;
         writeReg(A_CTRL, {24'h000000, ctrl});
         writeReg(A_SEL, {30'h00000000, sel});
         writeReg(A_PRE, 32'h00000010);
         readCheck(A_CTRL, {24'h000000, ctrl}, "ctrl");
         repeat (300) @(posedge clk);
         n1 = 96 / tickPer({ctrl[0], sel[0]}, m, d) + 16;
         n2 = 48 / tickPer({ctrl[1], sel[1]}, m, d);
         readRange(A_CNT1, n1 - 1, n1, "count1");
         readRange(A_CNT2, n2 - 1, n2, "count2");
      end
   endtask

   // saturation, then restart by preload write
   task automatic testRestart();
      writeReg(A_CTRL, 32'h00000004);
      writeReg(A_SEL, 32'h00000000);
      writeReg(A_PRE, 32'h000000F0);
      repeat (300) @(posedge clk);
      readRange(A_CNT1, 255, 255, "count1 sat");
      fanRun <= 1'b0;
      halfOne <= 8'h20;
      halfTwo <= 8'h10;
      repeat (200) @(posedge clk);
      writeReg(A_PRE, 32'h00000000);
      readCheck(A_CNT1, 32'h000000FF, "count1 kept");
      readCheck(A_CNT1, 32'h000000FF, "count1 idle");
      readCheck(A_PRE, 32'h00000000, "preload");
      fanRun <= 1'b1;
      repeat (50) @(posedge clk);
      readCheck(A_CNT1, 32'h000000FF, "count1 armed");
      repeat (200) @(posedge clk);
      readRange(A_CNT1, 63, 64, "count1 new");
      readRange(A_CNT2, 15, 16, "count2 new");
   endtask

   // verdict and end of run
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // watchdog
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      print_verdict();
   end

   // main sequence
   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      fanRun = 1'b0;
      halfOne = 8'h30;
      halfTwo = 8'h18;
      n_mismatch = 0;
      n_checks = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      testResetValues();
      fanRun <= 1'b1;
      testRates();
      testRestart();
      print_verdict();
   end
endmodule
